// *** pkg/acc_ops_regs.svh ***
// bit-position and reset constants for the accumulator operation group
`ifndef ACC_OPS_REGS_SVH
`define ACC_OPS_REGS_SVH
`define ACC_RESET_VAL   8'h00
`define FLAG_RESET_VAL  1'b0
`define STROBE_RESET_VAL 1'b0
`define WDATA_RESET_VAL 8'h00
`define HALF_CARRY_BIT  4
`define SIGN_BIT        7
`endif

// *** pkg/acc_ops_pkg.sv ***
// operation codes and state types for the accumulator operation group
package acc_ops_pkg;
  // operations executed by the datapath
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD_TO_MEM,
    OP_AND_TO_ACC,
    OP_AND_IMM,
    OP_AND_TO_MEM,
    OP_LOAD_ACC     // accumulator load from the immediate bus
  } op_e;
  // write-back sequencer states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_DONE
  } seq_e;
endpackage

// *** design/acc_alu_core.sv ***
// combinational adder and logic unit with flag computation
`timescale 1ns/100ps
`default_nettype none
`include "acc_ops_regs.svh"
module acc_alu_core (
  // operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  // results
  output logic [7:0] sum,
  output logic [7:0] conj,
  output logic       carry,
  output logic       half_carry,
  output logic       overflow,
  output logic       sum_zero,
  output logic       conj_zero,
  output logic       signed_cond
);
  // nine-bit sum keeps the carry out
  wire [8:0] full_sum = {1'b0, a} + {1'b0, b};
  // low nibble sum yields the half carry
  wire [4:0] low_sum  = {1'b0, a[3:0]} + {1'b0, b[3:0]};

  assign sum        = full_sum[7:0];
  assign conj       = a & b;
  assign carry      = full_sum[8];
  assign half_carry = low_sum[`HALF_CARRY_BIT];
  // overflow when like-signed operands give an unlike-signed sum
  assign overflow   = (a[`SIGN_BIT] == b[`SIGN_BIT]) &&
                      (sum[`SIGN_BIT] != a[`SIGN_BIT]);
  assign sum_zero   = (sum == 8'h00);
  assign conj_zero  = (conj == 8'h00);
  // true sign of the result regardless of overflow
  assign signed_cond = overflow ^ sum[`SIGN_BIT];
endmodule
`default_nettype wire

// *** design/acc_add_and_ops.sv ***
// accumulator add and logical-and instruction datapath with status flags
`timescale 1ns/100ps
`default_nettype none
`include "acc_ops_regs.svh"
module acc_add_and_ops (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                RST_N,
  // instruction issue
  input  wire logic                OP_VALID,
  input  wire acc_ops_pkg::op_e    OP_CODE,
  input  wire logic [7:0]          MEM_RDATA,
  input  wire logic [7:0]          IMM_DATA,
  // memory write-back
  output logic                     MEM_WE,
  output logic [7:0]               MEM_WDATA,
  // architectural state
  output logic [7:0]               ACC,
  output logic                     ZERO_FLAG,
  output logic                     CARRY_FLAG,
  output logic                     HALF_CARRY_FLAG,
  output logic                     OVERFLOW_FLAG,
  output logic                     SIGNED_CONDITION_FLAG
);
  // registered state
  logic [7:0] acc_ff;          // accumulator
  logic       zero_ff;         // zero flag
  logic       carry_ff;        // carry flag
  logic       half_carry_ff;   // half carry flag
  logic       overflow_ff;     // overflow flag
  logic       signed_cond_ff;  // signed-condition flag
  logic       mem_we_ff;       // write-back strobe
  logic [7:0] mem_wdata_ff;    // write-back data

  // alu results
  logic [7:0] alu_sum;
  logic [7:0] alu_conj;
  logic       alu_carry;
  logic       alu_half;
  logic       alu_ovf;
  logic       alu_sum_zero;
  logic       alu_conj_zero;
  logic       alu_signed;

  // true when the issued operation matches the wanted code
  function automatic logic op_hit(input logic             valid,
                                  input acc_ops_pkg::op_e code,
                                  input acc_ops_pkg::op_e want);
    return valid && (code == want);
  endfunction

  // immediate form swaps memory operand for instruction data
  wire        is_imm   = op_hit(OP_VALID, OP_CODE, acc_ops_pkg::OP_AND_IMM);
  wire [7:0]  operand  = is_imm ? IMM_DATA : MEM_RDATA;

  acc_alu_core u_alu (
    .a           (acc_ff),
    .b           (operand),
    .sum         (alu_sum),
    .conj        (alu_conj),
    .carry       (alu_carry),
    .half_carry  (alu_half),
    .overflow    (alu_ovf),
    .sum_zero    (alu_sum_zero),
    .conj_zero   (alu_conj_zero),
    .signed_cond (alu_signed)
  );

  // operation decode
  wire do_add     = op_hit(OP_VALID, OP_CODE, acc_ops_pkg::OP_ADD_TO_MEM);
  wire do_and_acc = op_hit(OP_VALID, OP_CODE, acc_ops_pkg::OP_AND_TO_ACC);
  wire do_and_mem = op_hit(OP_VALID, OP_CODE, acc_ops_pkg::OP_AND_TO_MEM);
  // load is how the rest of the core sets the accumulator; without it
  // only the and forms touch it and every add starts from reset value
  wire do_load    = op_hit(OP_VALID, OP_CODE, acc_ops_pkg::OP_LOAD_ACC);
  // explicit no-op, only watched by the checks below
  wire do_none    = op_hit(OP_VALID, OP_CODE, acc_ops_pkg::OP_NONE);
  // the and forms that land in the accumulator
  wire to_acc     = do_and_acc || is_imm;
  // any and form writes the zero flag
  wire any_and    = to_acc || do_and_mem;

  // next values
  wire [7:0] nxt_acc       = do_load ? IMM_DATA :
                             to_acc  ? alu_conj : acc_ff;
  wire       nxt_zero      = do_add  ? alu_sum_zero :
                             any_and ? alu_conj_zero : zero_ff;
  // and forms leave the arithmetic flags alone
  wire       nxt_carry     = do_add ? alu_carry  : carry_ff;
  wire       nxt_half      = do_add ? alu_half   : half_carry_ff;
  wire       nxt_ovf       = do_add ? alu_ovf    : overflow_ff;
  wire       nxt_signed    = do_add ? alu_signed : signed_cond_ff;
  // memory targets: sum for add, conjunction for and-to-memory
  wire       nxt_mem_we    = do_add || do_and_mem;
  wire [7:0] nxt_mem_wdata = do_add ? alu_sum :
                             do_and_mem ? alu_conj : mem_wdata_ff;

  // accumulator and flags
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_ff         <= `ACC_RESET_VAL;
      zero_ff        <= `FLAG_RESET_VAL;
      carry_ff       <= `FLAG_RESET_VAL;
      half_carry_ff  <= `FLAG_RESET_VAL;
      overflow_ff    <= `FLAG_RESET_VAL;
      signed_cond_ff <= `FLAG_RESET_VAL;
    end else begin
      acc_ff         <= nxt_acc;
      zero_ff        <= nxt_zero;
      carry_ff       <= nxt_carry;
      half_carry_ff  <= nxt_half;
      overflow_ff    <= nxt_ovf;
      signed_cond_ff <= nxt_signed;
    end
  end

  // memory write-back, one-cycle strobe with held data
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mem_we_ff    <= `STROBE_RESET_VAL;
      mem_wdata_ff <= `WDATA_RESET_VAL;
    end else begin
      mem_we_ff    <= nxt_mem_we;
      mem_wdata_ff <= nxt_mem_wdata;
    end
  end

  // outputs straight from flops
  assign MEM_WE                = mem_we_ff;
  assign MEM_WDATA             = mem_wdata_ff;
  assign ACC                   = acc_ff;
  assign ZERO_FLAG             = zero_ff;
  assign CARRY_FLAG            = carry_ff;
  assign HALF_CARRY_FLAG       = half_carry_ff;
  assign OVERFLOW_FLAG         = overflow_ff;
  assign SIGNED_CONDITION_FLAG = signed_cond_ff;

  // sign-extended sum, an independent view of the signed add flags
  wire [8:0] ext_sum = {acc_ff[7], acc_ff} + {MEM_RDATA[7], MEM_RDATA};

  // issue events; every result shows one cycle after its issue
  sequence s_add_issue;
    do_add;
  endsequence

  sequence s_and_issue;
    any_and;
  endsequence

  sequence s_mem_issue;
    do_add || do_and_mem;
  endsequence

  a_add_writes_sum: assert property (
    @(posedge CLK) disable iff (!RST_N)
    s_add_issue |=> MEM_WE && (MEM_WDATA == $past(ext_sum[7:0]))
      && (ACC == $past(acc_ff)))
    else $error("add did not write sum to memory");
  a_add_carry_flag: assert property (
    @(posedge CLK) disable iff (!RST_N)
    s_add_issue |=> CARRY_FLAG ==
      $past(({1'b0, acc_ff} + {1'b0, MEM_RDATA}) > 9'h0FF))
    else $error("add carry flag wrong");
  a_add_half_flag: assert property (
    @(posedge CLK) disable iff (!RST_N)
    s_add_issue |=> HALF_CARRY_FLAG ==
      $past(({1'b0, acc_ff[3:0]} + {1'b0, MEM_RDATA[3:0]}) > 5'h0F))
    else $error("add half carry flag wrong");
  // signed overflow: the two top bits of the extended sum disagree
  a_add_ovf_flag: assert property (
    @(posedge CLK) disable iff (!RST_N)
    s_add_issue |=> OVERFLOW_FLAG == $past(ext_sum[8] ^ ext_sum[7]))
    else $error("add overflow flag wrong");
  // true sign is the top bit of the extended sum
  a_add_sign_flag: assert property (
    @(posedge CLK) disable iff (!RST_N)
    s_add_issue |=> SIGNED_CONDITION_FLAG == $past(ext_sum[8]))
    else $error("add signed condition flag wrong");
  a_add_zero_flag: assert property (
    @(posedge CLK) disable iff (!RST_N)
    s_add_issue |=> ZERO_FLAG == ($past(ext_sum[7:0]) == 8'h00))
    else $error("add zero flag wrong");
  a_and_acc_result: assert property (
    @(posedge CLK) disable iff (!RST_N)
    do_and_acc |=> (ACC == $past(acc_ff & MEM_RDATA)) && !MEM_WE)
    else $error("and to accumulator wrong");
  a_and_keeps_flags: assert property (
    @(posedge CLK) disable iff (!RST_N)
    s_and_issue |=> $stable(CARRY_FLAG) && $stable(OVERFLOW_FLAG)
      && $stable(HALF_CARRY_FLAG) && $stable(SIGNED_CONDITION_FLAG))
    else $error("and altered arithmetic flags");
  a_and_imm_result: assert property (
    @(posedge CLK) disable iff (!RST_N)
    is_imm |=> (ACC == $past(acc_ff & IMM_DATA)) && !MEM_WE)
    else $error("and immediate wrong");
  a_and_mem_write: assert property (
    @(posedge CLK) disable iff (!RST_N)
    do_and_mem |=> MEM_WE && (MEM_WDATA == $past(acc_ff & MEM_RDATA))
      && $stable(ACC))
    else $error("and to memory wrong");
  a_zero_tracks: assert property (
    @(posedge CLK) disable iff (!RST_N)
    s_and_issue |=> ZERO_FLAG == ($past(acc_ff & operand) == 8'h00))
    else $error("zero flag wrong after and");
  // the strobe drops unless another memory op follows at once
  a_we_one_pulse: assert property (
    @(posedge CLK) disable iff (!RST_N)
    s_mem_issue ##1 !(do_add || do_and_mem) |=> !MEM_WE)
    else $error("write strobe held too long");
  a_idle_no_write: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !OP_VALID |=> !MEM_WE && $stable(ACC) && $stable(ZERO_FLAG))
    else $error("state changed without issue");
  a_none_no_change: assert property ( // an issued no-op leaves state
    @(posedge CLK) disable iff (!RST_N)
    do_none |=> !MEM_WE && $stable(ACC) && $stable(ZERO_FLAG)
      && $stable(CARRY_FLAG))
    else $error("no-op changed state");
  a_load_acc: assert property ( // load leaves flags and memory alone
    @(posedge CLK) disable iff (!RST_N)
    do_load |=> (ACC == $past(IMM_DATA)) && !MEM_WE
      && $stable(ZERO_FLAG) && $stable(CARRY_FLAG))
    else $error("accumulator load wrong");
endmodule
`default_nettype wire

// *** bench/acc_add_and_ops_tb.sv ***
// self-checking bench for the accumulator add and logical-and datapath
`timescale 1ns/100ps
`default_nettype none
module acc_add_and_ops_tb;
  logic             clk = 1'b0;     // core clock
  logic             rst_n = 1'b0;   // async reset, active low
  logic             op_valid = 1'b0;
  acc_ops_pkg::op_e op_code = acc_ops_pkg::OP_NONE;
  logic [7:0]       mem_rdata = 8'h00;
  logic [7:0]       imm_data = 8'h00;
  logic             mem_we;
  logic [7:0]       mem_wdata, acc;
  logic             zf, cf, hf, vf, sf;
  logic [7:0]       m_acc, m_wd;     // expected accumulator and write data
  logic             m_we, m_z, m_c, m_h, m_v, m_s;
  logic [31:0]      seed = 32'h0380E107;
  int               error_cnt = 0;
  int               checked = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  acc_add_and_ops dut (.CLK(clk), .RST_N(rst_n), .OP_VALID(op_valid),
    .OP_CODE(op_code), .MEM_RDATA(mem_rdata), .IMM_DATA(imm_data),
    .MEM_WE(mem_we), .MEM_WDATA(mem_wdata), .ACC(acc), .ZERO_FLAG(zf),
    .CARRY_FLAG(cf), .HALF_CARRY_FLAG(hf), .OVERFLOW_FLAG(vf),
    .SIGNED_CONDITION_FLAG(sf));
  // repeatable random source
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // one comparison, case equality so unknowns never match
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // reset design and model off a falling edge, so an op issued by the
  // step before is taken first and no input is driven twice at once
  task automatic do_reset(input int n);
    @(negedge clk);
    rst_n = 1'b0;
    op_valid = 1'b0;
    repeat (n) @(negedge clk);
    rst_n = 1'b1;
    {m_acc, m_wd, m_we, m_z, m_c, m_h, m_v, m_s} = '0;
  endtask
  // check previous result at falling edge, then issue the next op
  task automatic step(input logic v, input acc_ops_pkg::op_e op,
                      input logic [7:0] m, input logic [7:0] imm);
    logic [8:0] s9;
    logic [7:0] ef;
    logic [7:0] gf;
    @(negedge clk);
    ef = {4'h0, m_c, m_h, m_v, m_s};
    gf = {4'h0, cf, hf, vf, sf};
    chk("acc", m_acc, acc);
    chk("we", {7'h00, m_we}, {7'h00, mem_we});
    chk("wdata", m_wd, mem_wdata);
    chk("zero", {7'h00, m_z}, {7'h00, zf});
    chk("flags", ef, gf);
    op_valid = v;
    op_code = op;
    mem_rdata = m;
    imm_data = imm;
    m_we = 1'b0;
    if (v) begin
      case (op)
        acc_ops_pkg::OP_ADD_TO_MEM: begin
          s9 = {1'b0, m_acc} + {1'b0, m};
          m_we = 1'b1;
          m_wd = s9[7:0];
          m_c = s9[8];
          m_h = ({1'b0, m_acc[3:0]} + {1'b0, m[3:0]}) > 5'h0F;
          m_v = (m_acc[7] == m[7]) && (s9[7] != m[7]);
          m_s = m_v ^ s9[7];
          m_z = (s9[7:0] == 8'h00);
        end
        acc_ops_pkg::OP_AND_TO_ACC: begin
          m_acc = m_acc & m;
          m_z = (m_acc == 8'h00);
        end
        acc_ops_pkg::OP_AND_IMM: begin
          m_acc = m_acc & imm;
          m_z = (m_acc == 8'h00);
        end
        acc_ops_pkg::OP_AND_TO_MEM: begin
          m_we = 1'b1;
          m_wd = m_acc & m;
          m_z = (m_wd == 8'h00);
        end
        // load only sets the accumulator, flags untouched
        acc_ops_pkg::OP_LOAD_ACC: begin
          m_acc = imm;
        end
        default: ;
      endcase
    end
  endtask
  // main sequence: corners, random back-to-back traffic, reset mid-run
  initial begin
    logic [31:0]      r;
    acc_ops_pkg::op_e opr;
    do_reset(8);
    // 80 + 80: zero sum with carry and overflow
    step(1'b1, acc_ops_pkg::OP_LOAD_ACC, 8'h00, 8'h80);
    step(1'b1, acc_ops_pkg::OP_ADD_TO_MEM, 8'h80, 8'h00);
    step(1'b1, acc_ops_pkg::OP_ADD_TO_MEM, 8'h00, 8'h00);
    step(1'b1, acc_ops_pkg::OP_ADD_TO_MEM, 8'hFF, 8'h00);
    // 0F + 01: carry out of the low nibble only
    step(1'b1, acc_ops_pkg::OP_LOAD_ACC, 8'h00, 8'h0F);
    step(1'b1, acc_ops_pkg::OP_ADD_TO_MEM, 8'h01, 8'h00);
    step(1'b0, acc_ops_pkg::OP_AND_TO_ACC, 8'h00, 8'h00);
    step(1'b1, acc_ops_pkg::OP_AND_IMM, 8'h00, 8'hFF);
    step(1'b1, acc_ops_pkg::OP_AND_TO_MEM, 8'hA5, 8'h00);
    step(1'b1, acc_ops_pkg::OP_AND_TO_ACC, 8'hF0, 8'h00);
    step(1'b1, acc_ops_pkg::OP_NONE, 8'h3C, 8'hC3);
    for (int i = 0; i < 200; i++) begin
      r = xorshift();
      // one fresh reset at iteration 120, mid traffic
      if (i == 120) do_reset(2);
      opr = acc_ops_pkg::op_e'(3'(r[2:0] % 3'h6));
      step(r[31], opr, r[15:8], r[23:16]);
    end
    step(1'b0, acc_ops_pkg::OP_NONE, 8'h00, 8'h00);
    step(1'b0, acc_ops_pkg::OP_NONE, 8'h00, 8'h00);
    complete_run();
  end
  // cut a hang short
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
